// [hdl/dtm_defs.svh]
// Purpose: Constants for the dual 8-bit timer block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes: Offsets are byte addresses
`ifndef DTM_DEFS_SVH
`define DTM_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DTM_OFS_CTRL0 8'h00
`define DTM_OFS_CTRL1 8'h04
`define DTM_OFS_CMP0 8'h08
`define DTM_OFS_CMP1 8'h0C
`define DTM_OFS_DUTY0 8'h10
`define DTM_OFS_DUTY1 8'h14
`define DTM_OFS_CFG 8'h18
`define DTM_OFS_STAT 8'h1C

// ****************************************************************
// Control register fields
// ****************************************************************
`define DTM_CTRL_FF_BIT 7
`define DTM_CTRL_SEL_HI 6
`define DTM_CTRL_SEL_LO 4
`define DTM_CTRL_RUN_BIT 3
`define DTM_CTRL_MODE_HI 2
`define DTM_CTRL_MODE_LO 0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define DTM_CTRL_RST 8'h00
`define DTM_CMP_RST 8'h00
`define DTM_DUTY_RST 8'h00
`define DTM_CNT_MAX 8'hFF
`define DTM_PRE_W 11
`define DTM_SLOW_DIV_W 3
`define DTM_RESP_OKAY 2'b00
`define DTM_RESP_SLVERR 2'b10

`endif

// [hdl/dtm_pkg.sv]
// Purpose: Types for the dual 8-bit timer block
// Assumes: Constants live in dtm_defs.svh
// Notes: Codes are written out in binary
package dtm_pkg;

  // Channel operating modes
  typedef enum logic [2:0] {
    DTM_MODE_TIMER = 3'b000,
    DTM_MODE_DIV = 3'b001,
    DTM_MODE_PWM = 3'b011,
    DTM_MODE_CASC = 3'b100
  } dtm_mode_t;

  // Source clock choices
  typedef enum logic [2:0] {
    DTM_SEL_DIV2K = 3'b000,
    DTM_SEL_DIV128 = 3'b001,
    DTM_SEL_DIV32 = 3'b010,
    DTM_SEL_DIV8 = 3'b011,
    DTM_SEL_SLOW = 3'b100,
    DTM_SEL_HALF = 3'b101,
    DTM_SEL_FAST = 3'b110,
    DTM_SEL_PIN = 3'b111
  } dtm_sel_t;

endpackage : dtm_pkg

// [hdl/dtm_timer.sv]
// Purpose: Two cascadable 8-bit timer/counter channels behind AXI4-Lite
// Assumes: All inputs synchronous to aclk; aclk is the fast clock
// Notes: Channel 0 is the lower channel, channel 1 the upper
//
// Overview of operation
// - Event mode counts falling edges of event pin
// - Event match raises irq, clears, keeps counting
// - Compare register unbuffered, written value acts immediately
// - Divider mode toggles flip-flop, clears, irq on match
// - Divider pin is inverse of flip-flop
// - Control write loads flip-flop; reset clears it
// - Stopped counter holds pin; change flip-flop afterwards
// - Bit 3 runs counter; bit 7 flip-flop value
// - PWM toggles at duty, toggles and clears at overflow
// - PWM pin is inverse of flip-flop
// - Duty double-buffered while running, direct when stopped
// - Duty read during PWM gives previous setting
// - Selectable prescaled sources; slow mode slow only
// - Cascaded 16-bit match raises upper irq, clears
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dtm_defs.svh"

module dtm_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock sources and power mode
  input wire logic slow_clk_in,
  input wire logic low_speed_mode,
  // Channel pins
  input wire logic [1:0] event_in_pin,
  output logic [1:0] divider_out_pin_n,
  output logic [1:0] pwm_out_pin_n,
  output logic [1:0] channel_match_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl_reg [2];
  logic [7:0] cmp_reg [2];
  logic [7:0] duty_act_reg [2];
  logic [7:0] duty_hold_reg [2];
  logic [7:0] cnt_reg [2];
  logic [1:0] ff_reg;
  logic [1:0] irq_reg;
  logic [1:0] ev_prev_reg;
  logic prescale_source_select;
  logic [`DTM_PRE_W-1:0] pre_reg;
  logic [`DTM_SLOW_DIV_W-1:0] slow_div_reg;
  logic slow_prev_reg;
  logic slow_tick;
  logic slow8_tick;
  logic [1:0] tick;
  logic casc;
  logic run16;
  logic [15:0] inc16;
  logic [15:0] cmp16;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic wr_do;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_cmp;
  logic [1:0] wr_duty;
  logic wr_cfg;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Source clock tick for one channel's select field
  function automatic logic sel_tick(input logic [2:0] sel,
                                    input logic [1:0] fall,
                                    input int unsigned ch);
    logic slow_only;
    slow_only = low_speed_mode;
    sel_tick = 1'b0;
    case (dtm_pkg::dtm_sel_t'(sel))
      dtm_pkg::DTM_SEL_DIV2K: begin
        if (prescale_source_select || slow_only) begin
          sel_tick = slow8_tick;
        end else begin
          sel_tick = &pre_reg;
        end
      end
      dtm_pkg::DTM_SEL_DIV128: sel_tick = !slow_only && (&pre_reg[6:0]);
      dtm_pkg::DTM_SEL_DIV32: sel_tick = !slow_only && (&pre_reg[4:0]);
      dtm_pkg::DTM_SEL_DIV8: sel_tick = !slow_only && (&pre_reg[2:0]);
      dtm_pkg::DTM_SEL_SLOW: sel_tick = slow_tick;
      dtm_pkg::DTM_SEL_HALF: sel_tick = !slow_only && pre_reg[0];
      dtm_pkg::DTM_SEL_FAST: sel_tick = !slow_only;
      dtm_pkg::DTM_SEL_PIN: sel_tick = fall[ch];
      default: sel_tick = 1'b0;
    endcase
  endfunction : sel_tick

  // Register read multiplexer
  function automatic logic [31:0] reg_read(input logic [7:0] addr);
    reg_read = 32'h0000_0000;
    case (addr)
      `DTM_OFS_CTRL0: reg_read = {24'h00_0000, ctrl_reg[0]};
      `DTM_OFS_CTRL1: reg_read = {24'h00_0000, ctrl_reg[1]};
      `DTM_OFS_CMP0: reg_read = {24'h00_0000, cmp_reg[0]};
      `DTM_OFS_CMP1: reg_read = {24'h00_0000, cmp_reg[1]};
      `DTM_OFS_DUTY0: reg_read = {24'h00_0000, duty_read(0)};
      `DTM_OFS_DUTY1: reg_read = {24'h00_0000, duty_read(1)};
      `DTM_OFS_CFG: reg_read = {31'h0000_0000, prescale_source_select};
      `DTM_OFS_STAT: reg_read = {14'h0000, ff_reg, cnt_reg[1], cnt_reg[0]};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  // Duty read: previous setting while PWM is running
  function automatic logic [7:0] duty_read(input int unsigned ch);
    logic pwm_run;
    pwm_run = ctrl_reg[ch][`DTM_CTRL_RUN_BIT] &&
      (ctrl_reg[ch][2:0] == dtm_pkg::DTM_MODE_PWM);
    duty_read = pwm_run ? duty_act_reg[ch] : duty_hold_reg[ch];
  endfunction : duty_read

  // Address is one of the mapped registers
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr[1:0] == 2'b00) && (addr <= `DTM_OFS_STAT);
  endfunction : is_mapped

  // ****************************************************************
  // Prescaler and source clocks
  // ****************************************************************

  // Free-running fast-clock divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + `DTM_PRE_W'(1);
    end
  end

  // Slow clock edge and divide by eight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_prev_reg <= 1'b0;
      slow_div_reg <= '0;
    end else begin
      slow_prev_reg <= slow_clk_in;
      if (slow_tick) begin
        slow_div_reg <= slow_div_reg + `DTM_SLOW_DIV_W'(1);
      end
    end
  end

  assign slow_tick = slow_clk_in && !slow_prev_reg;
  assign slow8_tick = slow_tick && (&slow_div_reg);

  // Event pin falling edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_prev_reg <= 2'b00;
    end else begin
      ev_prev_reg <= event_in_pin;
    end
  end

  // Per-channel source ticks and cascade terms
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      tick[k] = sel_tick(ctrl_reg[k][`DTM_CTRL_SEL_HI:`DTM_CTRL_SEL_LO],
                         ev_prev_reg & ~event_in_pin, k);
    end
  end

  assign casc = (ctrl_reg[1][2:0] == dtm_pkg::DTM_MODE_CASC);
  assign run16 = ctrl_reg[1][`DTM_CTRL_RUN_BIT];
  assign inc16 = {cnt_reg[1], cnt_reg[0]} + 16'h0001;
  assign cmp16 = {cmp_reg[1], cmp_reg[0]};

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************

  // Address and data capture, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_reg) ? `DTM_RESP_OKAY :
          `DTM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write strobes per register
  assign wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      wr_ctrl[k] = wr_do && wstrb0_reg &&
        (awaddr_reg == (`DTM_OFS_CTRL0 + 8'(4 * k)));
      wr_cmp[k] = wr_do && wstrb0_reg &&
        (awaddr_reg == (`DTM_OFS_CMP0 + 8'(4 * k)));
      wr_duty[k] = wr_do && wstrb0_reg &&
        (awaddr_reg == (`DTM_OFS_DUTY0 + 8'(4 * k)));
    end
  end
  assign wr_cfg = wr_do && wstrb0_reg && (awaddr_reg == `DTM_OFS_CFG);

  // Global configuration bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_source_select <= 1'b0;
    end else if (wr_cfg) begin
      prescale_source_select <= wdata_reg[0];
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************

  // Single read in flight, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DTM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_read(s_axi_araddr);
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `DTM_RESP_OKAY :
          `DTM_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch

    // Control and compare registers
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_reg[i] <= `DTM_CTRL_RST;
        cmp_reg[i] <= `DTM_CMP_RST;
      end else begin
        if (wr_ctrl[i]) begin
          ctrl_reg[i] <= wdata_reg;
        end
        if (wr_cmp[i]) begin
          cmp_reg[i] <= wdata_reg;
        end
      end
    end

    // Counter, flip-flop, duty buffer and match pulse
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_reg[i] <= 8'h00;
        ff_reg[i] <= 1'b0;
        irq_reg[i] <= 1'b0;
        duty_act_reg[i] <= `DTM_DUTY_RST;
        duty_hold_reg[i] <= `DTM_DUTY_RST;
      end else begin
        irq_reg[i] <= 1'b0;
        if (wr_ctrl[i]) begin
          ff_reg[i] <= wdata_reg[`DTM_CTRL_FF_BIT];
        end
        if (wr_duty[i]) begin
          duty_hold_reg[i] <= wdata_reg;
          if (!ctrl_reg[i][`DTM_CTRL_RUN_BIT]) begin
            duty_act_reg[i] <= wdata_reg;
          end
        end
        if (casc) begin
          // Cascaded 16-bit timer on the lower channel's clock
          if (run16 && tick[0]) begin
            if (inc16 == cmp16) begin
              cnt_reg[i] <= 8'h00;
              irq_reg[i] <= (i == 1);
            end else begin
              cnt_reg[i] <= inc16[8*i +: 8];
            end
          end
        end else if (ctrl_reg[i][`DTM_CTRL_RUN_BIT] && tick[i]) begin
          case (dtm_pkg::dtm_mode_t'(ctrl_reg[i][2:0]))
            dtm_pkg::DTM_MODE_TIMER: begin
              if (cnt_reg[i] + 8'h01 == cmp_reg[i]) begin
                cnt_reg[i] <= 8'h00;
                irq_reg[i] <= 1'b1;
              end else begin
                cnt_reg[i] <= cnt_reg[i] + 8'h01;
              end
            end
            dtm_pkg::DTM_MODE_DIV: begin
              if (cnt_reg[i] + 8'h01 == cmp_reg[i]) begin
                cnt_reg[i] <= 8'h00;
                ff_reg[i] <= !ff_reg[i];
                irq_reg[i] <= 1'b1;
              end else begin
                cnt_reg[i] <= cnt_reg[i] + 8'h01;
              end
            end
            dtm_pkg::DTM_MODE_PWM: begin
              if (cnt_reg[i] == `DTM_CNT_MAX) begin
                cnt_reg[i] <= 8'h00;
                ff_reg[i] <= !ff_reg[i];
                irq_reg[i] <= 1'b1;
                duty_act_reg[i] <= duty_hold_reg[i];
              end else begin
                cnt_reg[i] <= cnt_reg[i] + 8'h01;
                if (cnt_reg[i] + 8'h01 == duty_act_reg[i]) begin
                  ff_reg[i] <= !ff_reg[i];
                end
              end
            end
            default: begin
              cnt_reg[i] <= cnt_reg[i];
            end
          endcase
        end
      end
    end

    // Registered pins, inverse of the flip-flop
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        divider_out_pin_n[i] <= 1'b1;
        pwm_out_pin_n[i] <= 1'b1;
        channel_match_irq[i] <= 1'b0;
      end else begin
        divider_out_pin_n[i] <= !ff_reg[i];
        pwm_out_pin_n[i] <= !ff_reg[i];
        channel_match_irq[i] <= irq_reg[i];
      end
    end

  end : g_ch

endmodule : dtm_timer

// [tb/dtm_event_src.sv]
// Purpose: External event pulse source for both channel pins
// Assumes: Levels change only on aclk rising edges
// Notes: Idle level is high; HALF sets the speed
`timescale 1ns/1ps

module dtm_event_src #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic aclk,
  // Control from the bench
  input wire logic run,
  // Event pins
  output logic [1:0] level
);
  int cnt;

  initial level = 2'h3;
  initial cnt = 0;

  // Change level only at HALF boundaries; finish high when stopped
  always @(posedge aclk) begin
    if (cnt != HALF - 1) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
      if (run || level != 2'h3) begin
        level <= ~level;
      end
    end
  end
endmodule : dtm_event_src

// [tb/dtm_timer_monitor.sv]
// Purpose: Bus and pin checks for the dual timer
// Assumes: Sees top module ports only
// Notes: Bound at the foot of this file
`timescale 1ns/1ps

module dtm_timer_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [1:0] divider_out_pin_n,
  input wire logic [1:0] pwm_out_pin_n,
  input wire logic [1:0] channel_match_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Reset leaves pins idle high, no irq
  property p_reset_pins;
    disable iff (1'h0) !aresetn |=>
      divider_out_pin_n == 2'h3 && channel_match_irq == 2'h0;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pins not idle after reset");

  // Both pin kinds show the same flip-flop
  property p_pins_same;
    pwm_out_pin_n == divider_out_pin_n;
  endproperty
  a_pins_same: assert property (p_pins_same)
    else $error("divider and pwm pins differ");

  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write response late");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");

  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("read data late");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");

  property p_aw_stall;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_stall: assert property (p_aw_stall)
    else $error("write taken while outstanding");

  property p_ar_stall;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_stall: assert property (p_ar_stall)
    else $error("read taken while outstanding");

  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:18] == 14'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("unused read bits set");
endmodule : dtm_timer_chk

bind dtm_timer dtm_timer_chk dtm_timer_chk_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .divider_out_pin_n, .pwm_out_pin_n, .channel_match_irq);

// [tb/dtm_timer_tb_top.sv]
// Purpose: Scenario bench for the dual timer
// Assumes: aclk is the fast clock, 25 ns
// Notes: Event pins come from the partner model
`timescale 1ns/1ps
`include "dtm_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); \
  end end

module dtm_timer_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, ev_run = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, low_speed_mode = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, slow_clk_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, event_in_pin, channel_match_irq;
  logic [1:0] divider_out_pin_n, pwm_out_pin_n, ev_prev = 2'h3;
  logic [2:0] slow_div = 3'h0;
  logic pin_prev = 1'h1;
  int bad_count = 0, tests_run = 0, irq0 = 0, irq1 = 0, lo0 = 0;
  int tg0 = 0, falls = 0;

  dtm_timer dtm_timer_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .slow_clk_in, .low_speed_mode, .event_in_pin, .divider_out_pin_n,
    .pwm_out_pin_n, .channel_match_irq);

  dtm_event_src dtm_event_src_inst (.aclk, .run(ev_run),
    .level(event_in_pin));

  always #12.5 aclk = ~aclk;
  assign slow_clk_in = slow_div[2];

  // Slow clock source and running tallies of pin activity
  always @(posedge aclk) begin
    slow_div <= slow_div + 3'h1;
    irq0 <= irq0 + int'(channel_match_irq[0] === 1'h1);
    irq1 <= irq1 + int'(channel_match_irq[1] === 1'h1);
    lo0 <= lo0 + int'(pwm_out_pin_n[0] === 1'h0);
    tg0 <= tg0 + int'(divider_out_pin_n[0] !== pin_prev);
    pin_prev <= divider_out_pin_n[0];
    falls <= falls + int'(ev_prev[1] === 1'h1 && event_in_pin[1] === 1'h0);
    ev_prev <= event_in_pin;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      r = s_axi_bresp;
      done = (s_axi_bvalid === 1'h1);
    end
    s_axi_bready <= 1'h0;
    if (!done) bad_count++;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      done = (s_axi_rvalid === 1'h1);
    end
    s_axi_rready <= 1'h0;
    if (!done) bad_count++;
    @(posedge aclk);
  endtask : rd

  task automatic wait_irq0;
    int s, k;
    s = irq0;
    k = 0;
    while (irq0 == s && k < 1000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 1000) bad_count++;
  endtask : wait_irq0

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    `CHK("pins_n", 2'h3, divider_out_pin_n)
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), d, r);
      `CHK("reset value", 32'h0, d)
    end
    rd(8'h20, d, r);
    `CHK("unmapped read resp", `DTM_RESP_SLVERR, r)
    wr(8'h20, 8'h55, r);
    `CHK("unmapped write resp", `DTM_RESP_SLVERR, r)
    $display("reset test done");
  endtask : t_reset

  task automatic t_div;
    logic [31:0] d;
    logic [1:0] r;
    logic p;
    int i, t;
    wr(`DTM_OFS_CMP0, 8'h03, r);
    // Output latch loaded clear; pins are watched directly
    wr(`DTM_OFS_CTRL0, 8'h69, r);
    cyc(6);
    i = irq0;
    t = tg0;
    cyc(30);
    `CHK("divider irqs", 10, irq0 - i)
    `CHK("divider toggles", 10, tg0 - t)
    rd(`DTM_OFS_STAT, d, r);
    wr(`DTM_OFS_CTRL0, {d[16], 7'h61}, r);
    // Let a match taken on the stopping edge reach the tally first
    cyc(2);
    p = divider_out_pin_n[0];
    i = irq0;
    cyc(10);
    `CHK("held pin", p, divider_out_pin_n[0])
    `CHK("stopped irqs", 0, irq0 - i)
    rd(`DTM_OFS_STAT, d, r);
    `CHK("pin vs ff", ~d[16], divider_out_pin_n[0])
    wr(`DTM_OFS_CTRL0, 8'hE1, r);
    `CHK("pin ff set", 1'h0, divider_out_pin_n[0])
    wr(`DTM_OFS_CTRL0, 8'h61, r);
    `CHK("pin ff clear", 1'h1, divider_out_pin_n[0])
    $display("divider test done");
  endtask : t_div

  task automatic t_event;
    logic [31:0] d;
    logic [1:0] r;
    int f, i0, i1, k, n;
    t_mid_reset();
    wr(`DTM_OFS_CMP0, 8'h05, r);
    wr(`DTM_OFS_CMP1, 8'h04, r);
    wr(`DTM_OFS_CTRL0, 8'h78, r);
    wr(`DTM_OFS_CTRL1, 8'h78, r);
    f = falls;
    i0 = irq0;
    i1 = irq1;
    k = 0;
    ev_run <= 1'h1;
    while (falls - f < 6 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    ev_run <= 1'h0;
    cyc(12);
    n = falls - f;
    rd(`DTM_OFS_STAT, d, r);
    `CHK("event counts", {8'(n % 4), 8'(n % 5)}, d[15:0])
    `CHK("upper event irqs", n / 4, irq1 - i1)
    `CHK("lower event irqs", n / 5, irq0 - i0)
    wr(`DTM_OFS_CTRL0, 8'h00, r);
    wr(`DTM_OFS_CTRL1, 8'h00, r);
    $display("event test done");
  endtask : t_event

  task automatic t_pwm;
    logic [31:0] d;
    logic [1:0] r;
    int l;
    wr(`DTM_OFS_DUTY0, 8'h40, r);
    rd(`DTM_OFS_DUTY0, d, r);
    `CHK("stopped duty", 32'h40, d)
    wr(`DTM_OFS_CTRL0, 8'h6B, r);
    wait_irq0();
    l = lo0;
    cyc(256);
    `CHK("pwm low cycles", 192, lo0 - l)
    wait_irq0();
    wr(`DTM_OFS_DUTY0, 8'h80, r);
    rd(`DTM_OFS_DUTY0, d, r);
    `CHK("running duty read", 32'h40, d)
    wait_irq0();
    rd(`DTM_OFS_DUTY0, d, r);
    `CHK("loaded duty", 32'h80, d)
    l = lo0;
    cyc(256);
    `CHK("pwm low cycles new", 128, lo0 - l)
    wr(`DTM_OFS_CTRL0, 8'h00, r);
    $display("pwm test done");
  endtask : t_pwm

  task automatic t_casc;
    logic [1:0] r;
    int i0, i1;
    t_mid_reset();
    wr(`DTM_OFS_CMP1, 8'h01, r);
    wr(`DTM_OFS_CMP0, 8'h2C, r);
    wr(`DTM_OFS_CTRL0, 8'h60, r);
    wr(`DTM_OFS_CTRL1, 8'h0C, r);
    i0 = irq0;
    i1 = irq1;
    // Window reaches the tally of the second match pulse
    cyc(620);
    `CHK("cascade irqs", 2, irq1 - i1)
    `CHK("lower irqs in cascade", 0, irq0 - i0)
    wr(`DTM_OFS_CTRL1, 8'h00, r);
    $display("cascade test done");
  endtask : t_casc

  // Reset in mid-run; counters and flip-flops return to zero
  task automatic t_mid_reset;
    logic [31:0] d;
    logic [1:0] r;
    aresetn <= 1'h0;
    cyc(2);
    aresetn <= 1'h1;
    cyc(1);
    `CHK("mid reset pins", 2'h3, divider_out_pin_n)
    rd(`DTM_OFS_STAT, d, r);
    `CHK("mid reset status", 32'h0, d)
  endtask : t_mid_reset

  // Every internal source select but FAST, one match per tick with compare 1
  task automatic t_clk;
    logic [1:0] r;
    int i;
    int per[7] = '{2, 8, 32, 128, 8, 64, 0};
    logic [2:0] sel[7] = '{3'h5, 3'h3, 3'h2, 3'h1, 3'h4, 3'h0, 3'h3};
    t_mid_reset();
    wr(`DTM_OFS_CFG, 8'h01, r);
    wr(`DTM_OFS_CMP0, 8'h01, r);
    for (int k = 0; k < 7; k++) begin
      low_speed_mode <= (k == 6);
      wr(`DTM_OFS_CTRL0, {1'h0, sel[k], 4'h8}, r);
      cyc(4);
      i = irq0;
      cyc(256);
      `CHK("source ticks", (per[k] == 0) ? 0 : 256 / per[k], irq0 - i)
    end
    low_speed_mode <= 1'h0;
    wr(`DTM_OFS_CTRL0, 8'h00, r);
    $display("clock test done");
  endtask : t_clk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_div();
    t_event();
    t_pwm();
    t_casc();
    t_clk();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end
endmodule : dtm_timer_tb_top
